// ### rtl/uoi_pkg.sv
// package of constants and types for the out endpoint interrupt flag block
// Summary of operation
// - bits 7 to 4 of the flag register read zero; writes to them are ignored
// - a software read returns current flags, then clears every pending flag except those with an event in the read cycle
// - bits 3, 2, 1 hold pending flags of out endpoints 3, 2, 1
// - eight-bit read-only flag register at address 0x04, bit 0 reads zero
// - interrupt request o_usb_irq is high whenever any pending flag is set
`default_nettype none
package uoi_pkg;
  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OUT_FLAGS_ADDR = 8'h04;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h10;
  localparam logic [7:0] IRQ_CLEAR_ADDR = 8'h11;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h12;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // ---------------------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------------------
  localparam int EP_FIRST_BIT = 1;
  localparam int EP_COUNT = 3;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic [2:0] ENABLE_RESET = 3'h7;
  localparam logic [2:0] STATUS_RESET = 3'h0;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uoi_bus_req_t;
endpackage : uoi_pkg
`default_nettype wire

// ### rtl/uoi_out_ep_irq_flags.sv
// out endpoint interrupt pending flags with read-to-clear register
`timescale 1ns/10ps
`default_nettype none
module uoi_out_ep_irq_flags (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire uoi_pkg::uoi_bus_req_t i_bus,
  input wire logic [2:0] i_out_ep_event,
  output logic [7:0] o_rdata,
  output logic o_usb_irq,
  output logic o_irq
);
  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  logic rd_flags;
  logic rd_status;
  logic rd_enable;
  logic wr_clear;
  logic wr_enable;
  logic [2:0] flags_q;
  logic [2:0] flags_d;
  logic [2:0] status_q;
  logic [2:0] status_d;
  logic [2:0] enable_q;

  assign rd_flags = i_bus.rd && (i_bus.addr == uoi_pkg::OUT_FLAGS_ADDR);
  assign rd_status = i_bus.rd && (i_bus.addr == uoi_pkg::IRQ_STATUS_ADDR);
  assign rd_enable = i_bus.rd && (i_bus.addr == uoi_pkg::IRQ_ENABLE_ADDR);
  assign wr_clear = i_bus.wr && (i_bus.addr == uoi_pkg::IRQ_CLEAR_ADDR);
  assign wr_enable = i_bus.wr && (i_bus.addr == uoi_pkg::IRQ_ENABLE_ADDR);

  // ---------------------------------------------------------------------------
  // pending flags
  // ---------------------------------------------------------------------------
  always_comb begin
    flags_d = flags_q;
    if (rd_flags) begin
      flags_d = uoi_pkg::FLAGS_RESET;
    end
    flags_d = flags_d | i_out_ep_event;
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      flags_q <= uoi_pkg::FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ---------------------------------------------------------------------------
  // sticky status, clear and enable
  // ---------------------------------------------------------------------------
  always_comb begin
    status_d = status_q;
    if (wr_clear) begin
      status_d = status_q & ~i_bus.wdata[3:1];
    end
    status_d = status_d | i_out_ep_event;
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      status_q <= uoi_pkg::STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      enable_q <= uoi_pkg::ENABLE_RESET;
    end else if (wr_enable) begin
      enable_q <= i_bus.wdata[3:1];
    end
  end

  // ---------------------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= uoi_pkg::UNMAPPED_READ;
    end else if (rd_flags) begin
      o_rdata <= {4'h0, flags_q, 1'h0};
    end else if (rd_status) begin
      o_rdata <= {4'h0, status_q, 1'h0};
    end else if (rd_enable) begin
      o_rdata <= {4'h0, enable_q, 1'h0};
    end else begin
      o_rdata <= uoi_pkg::UNMAPPED_READ;
    end
  end

  // ---------------------------------------------------------------------------
  // interrupt outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_usb_irq <= 1'h0;
      o_irq <= 1'h0;
    end else begin
      o_usb_irq <= |flags_d;
      o_irq <= |(status_d & enable_q);
    end
  end
endmodule : uoi_out_ep_irq_flags
`default_nettype wire

// ### verification/uoi_props.sv
// assertions on the out endpoint flag block ports
`timescale 1ns/10ps
`default_nettype none
module uoi_props (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire uoi_pkg::uoi_bus_req_t i_bus,
  input wire logic [2:0] i_out_ep_event,
  input wire logic [7:0] o_rdata,
  input wire logic o_usb_irq,
  input wire logic o_irq
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  wire logic rd4 = i_bus.rd && i_bus.addr == 8'h04;
  AST_HI: assert property (o_rdata[7:4] == 4'h0) else $error("high bits set");
  AST_B0: assert property (o_rdata[0] == 1'b0) else $error("bit0 set");
  AST_CLR: assert property (rd4 && i_out_ep_event == 3'h0 |=> !o_usb_irq)
    else $error("read kept flags");
  AST_SHOW: assert property (rd4 && o_usb_irq |=> o_rdata[3:1] != 3'h0)
    else $error("flags not shown");
  AST_CAUSE: assert property ($rose(o_usb_irq) |-> $past(i_out_ep_event) != 3'h0)
    else $error("irq without event");
  AST_SET: assert property (i_out_ep_event != 3'h0 |=> o_usb_irq)
    else $error("event lost");
endmodule : uoi_props
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the out endpoint flag block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  uoi_pkg::uoi_bus_req_t b = '0;
  logic [2:0] ev = 3'h0;
  logic [7:0] o_rdata;
  logic o_usb_irq, o_irq;
  int fails = 0, num_checks = 0;
  uoi_out_ep_irq_flags i_uoi_out_ep_irq_flags (.i_clock, .i_rstn, .i_bus(b),
    .i_out_ep_event(ev), .o_rdata, .o_usb_irq, .o_irq);
  initial forever #2 i_clock = ~i_clock;
  task chk(input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task rd(input logic [7:0] a, e);
    @(posedge i_clock) b <= {a, 8'h00, 2'h1};
    @(posedge i_clock) b.rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask : rd
  task wr(input logic [7:0] a, d);
    @(posedge i_clock) b <= {a, d, 2'h2};
    @(posedge i_clock) b.wr <= 1'b0;
  endtask : wr
  task irq(input logic [7:0] e);
    repeat (2) @(posedge i_clock);
    #1 chk({7'h00, o_irq}, e);
  endtask : irq
  task t_reg;
    rd(8'h12, 8'h0e);
    wr(8'h04, 8'hff);
    rd(8'h20, 8'h00);
    rd(8'h04, 8'h00);
    $display("t_reg end");
  endtask : t_reg
  task t_ep;
    for (int k = 1; k < 4; k++) begin
      @(posedge i_clock) ev <= 3'(1 << (k - 1));
      @(posedge i_clock) ev <= 3'h0;
      #1 chk({6'h00, o_irq, o_usb_irq}, 8'h03);
      rd(8'h04, 8'(1 << k));
      chk({7'h00, o_usb_irq}, 8'h00);
      rd(8'h04, 8'h00);
    end
    rd(8'h10, 8'h0e);
    $display("t_ep end");
  endtask : t_ep
  task t_irq;
    wr(8'h11, 8'h0e);
    wr(8'h12, 8'h00);
    @(posedge i_clock) {b, ev} <= {8'h04, 8'h00, 2'h1, 3'h4};
    @(posedge i_clock) {b, ev} <= '0;
    #1 chk(o_rdata, 8'h00);
    rd(8'h04, 8'h08);
    irq(8'h00);
    wr(8'h12, 8'h08);
    irq(8'h01);
    wr(8'h11, 8'h08);
    irq(8'h00);
    $display("t_irq end");
  endtask : t_irq
  task t_rst;
    wr(8'h12, 8'h00);
    @(posedge i_clock) ev <= 3'h2;
    @(posedge i_clock) begin
      ev <= 3'h0;
      i_rstn <= 1'b0;
    end
    #1 chk({6'h00, o_irq, o_usb_irq}, 8'h00);
    repeat (6) @(posedge i_clock);
    i_rstn <= 1'b1;
    rd(8'h12, 8'h0e);
    rd(8'h10, 8'h00);
    rd(8'h04, 8'h00);
    $display("t_rst end");
  endtask : t_rst
  task report_and_stop;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (6) @(posedge i_clock);
    i_rstn <= 1'b1;
    t_reg();
    t_ep();
    t_irq();
    t_rst();
    report_and_stop();
  end
endmodule : tb_top
bind uoi_out_ep_irq_flags uoi_props i_uoi_props (.i_clock, .i_rstn, .i_bus,
  .i_out_ep_event, .o_rdata, .o_usb_irq, .o_irq);
`default_nettype wire
